// ===== src/itc_pkg.sv
// Purpose: constants and types for the interval timer control/status block
// Assumes: byte-wide i/o port access, three counters
// Notes:   port addresses are i/o addresses, 8-bit data
package itc_pkg;
    localparam logic [7:0] ITC_PORT_CNT0 = 8'h40;
    localparam logic [7:0] ITC_PORT_CNT1 = 8'h41;
    localparam logic [7:0] ITC_PORT_CNT2 = 8'h42;
    localparam logic [7:0] ITC_PORT_CTRL = 8'h43;

    localparam int ITC_NUM_CNT = 3;

    // control byte fields
    localparam int ITC_SEL_HI  = 7;
    localparam int ITC_SEL_LO  = 6;
    localparam int ITC_ACC_HI  = 5;
    localparam int ITC_ACC_LO  = 4;
    localparam int ITC_MODE_HI = 3;
    localparam int ITC_MODE_LO = 1;
    localparam int ITC_BCD_BIT = 0;

    // read-back command fields
    localparam int ITC_RB_NCOUNT  = 5;
    localparam int ITC_RB_NSTATUS = 4;
    localparam int ITC_RB_CNT0    = 1;

    localparam logic [1:0] ITC_SEL_READBACK = 2'h3;
    localparam logic [1:0] ITC_ACC_LATCH    = 2'h0;
    localparam logic [1:0] ITC_ACC_LSB      = 2'h1;
    localparam logic [1:0] ITC_ACC_MSB      = 2'h2;
    localparam logic [1:0] ITC_ACC_BOTH     = 2'h3;

    localparam logic [1:0] ITC_ACC_RESET  = 2'h3;
    localparam logic [2:0] ITC_MODE_RESET = 3'h0;
    localparam logic [7:0] ITC_RDATA_IDLE = 8'h00;

    // mode decode: bit 3 is a don't-care when bit 2 is set
    function automatic logic [2:0] itc_decode_mode(input logic [2:0] m);
        itc_decode_mode = m[1] ? {1'b0, m[1:0]} : m;
    endfunction : itc_decode_mode
endpackage : itc_pkg

// ===== src/itc_status_reg.sv
// Purpose: per-counter programmed settings and pending-load flag
// Assumes: write strobes come from the control port decode
// Notes:   one instance per counter
`timescale 1ns/1ns
`default_nettype none
module itc_status_reg
    import itc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // programming
    input  wire logic       ctrl_we,
    input  wire logic [7:0] ctrl_byte,
    input  wire logic       count_we,
    input  wire logic       count_loaded,
    // state
    output logic [1:0]      acc_q,
    output logic [2:0]      mode_q,
    output logic            bcd_q,
    output logic            pending_load_flag_q
);
    logic [1:0] acc_d;
    logic [2:0] mode_d;
    logic       bcd_d;
    logic       pending_load_flag_d;

    always_comb begin
        acc_d               = acc_q;
        mode_d              = mode_q;
        bcd_d               = bcd_q;
        pending_load_flag_d = pending_load_flag_q;
        if (count_loaded) begin
            pending_load_flag_d = 1'b0;
        end
        // latch command leaves the programmed settings alone
        if (ctrl_we && ctrl_byte[ITC_ACC_HI:ITC_ACC_LO] != ITC_ACC_LATCH) begin
            acc_d               = ctrl_byte[ITC_ACC_HI:ITC_ACC_LO];
            mode_d              = itc_decode_mode(ctrl_byte[ITC_MODE_HI:ITC_MODE_LO]);
            bcd_d               = ctrl_byte[ITC_BCD_BIT];
            pending_load_flag_d = 1'b1;
        end
        // a new write wins over a load in the same cycle
        if (count_we) begin
            pending_load_flag_d = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            acc_q               <= ITC_ACC_RESET;
            mode_q              <= ITC_MODE_RESET;
            bcd_q               <= 1'b0;
            pending_load_flag_q <= 1'b1;
        end else begin
            acc_q               <= acc_d;
            mode_q              <= mode_d;
            bcd_q               <= bcd_d;
            pending_load_flag_q <= pending_load_flag_d;
        end
    end
endmodule : itc_status_reg
`default_nettype wire

// ===== src/itc_control_status.sv
// Purpose: control port decode and read-back status bytes of a three-counter timer
// Assumes: counter cores outside; out pins arrive asynchronously
// Notes:   status byte appears at a data port only after a read-back asks for it
//
// Notes on behaviour
// - status bit 7 shows counter output level
// - status bits 5:4 echo byte-access code
// - status bits 3:1 echo programmed mode code
// - status bit 0 shows binary or bcd
// - select field picks counter; 11 is read-back
// - access field: latch, lsb, msb, lsb-then-msb
// - mode field selects one of six modes
// - mode msb ignored for modes 2 and 3
// - bit 0 selects binary or bcd counting
// - new count applied when mode says so
// - status returned only after read-back request
`timescale 1ns/1ns
`default_nettype none
module itc_control_status
    import itc_pkg::*;
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       sys_rst,
    // i/o port access
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [7:0] io_addr,
    input  wire logic [7:0] io_wdata,
    output logic [7:0]      io_rdata,
    output logic            io_rvalid,
    // counter cores
    input  wire logic [2:0] cnt_out,
    input  wire logic [2:0] cnt_loaded,
    output logic [2:0]      cnt_ctrl_we,
    output logic [2:0]      cnt_count_we,
    output logic [2:0]      cnt_latch_req,
    output logic [7:0]      cnt_wdata,
    output logic [2:0]      cnt_mode0,
    output logic [2:0]      cnt_mode1,
    output logic [2:0]      cnt_mode2,
    output logic [2:0]      cnt_bcd,
    output logic [1:0]      cnt_acc0,
    output logic [1:0]      cnt_acc1,
    output logic [1:0]      cnt_acc2
);
    logic [2:0] out_meta_q;
    logic [2:0] out_sync_q;
    logic [2:0] status_armed_q;
    logic [2:0] status_armed_d;
    logic [7:0] io_rdata_d;
    logic       io_rvalid_d;
    logic [2:0] ctrl_we_d;
    logic [2:0] count_we_d;
    logic [2:0] latch_d;
    logic [2:0] ctrl_we_q;
    logic [2:0] count_we_q;
    logic [2:0] latch_q;
    logic [7:0] wdata_q;
    logic [1:0] acc   [ITC_NUM_CNT];
    logic [2:0] mode  [ITC_NUM_CNT];
    logic       bcd   [ITC_NUM_CNT];
    logic       pend  [ITC_NUM_CNT];
    logic [1:0] sel;
    logic       ctrl_hit;

    assign sel      = io_wdata[ITC_SEL_HI:ITC_SEL_LO];
    assign ctrl_hit = io_wr && io_addr == ITC_PORT_CTRL;

    function automatic logic [1:0] port_index(input logic [7:0] a);
        port_index = a[1:0];
    endfunction : port_index

    function automatic logic is_data_port(input logic [7:0] a);
        is_data_port = a == ITC_PORT_CNT0 || a == ITC_PORT_CNT1 || a == ITC_PORT_CNT2;
    endfunction : is_data_port

    for (genvar i = 0; i < ITC_NUM_CNT; i++) begin : g_cnt
        itc_status_reg u_status (
            .mclk                (mclk),
            .sys_rst             (sys_rst),
            .ctrl_we             (ctrl_we_d[i]),
            .ctrl_byte           (io_wdata),
            .count_we            (count_we_d[i]),
            .count_loaded        (cnt_loaded[i]),
            .acc_q               (acc[i]),
            .mode_q              (mode[i]),
            .bcd_q               (bcd[i]),
            .pending_load_flag_q (pend[i])
        );
    end

    always_comb begin
        ctrl_we_d      = '0;
        count_we_d     = '0;
        latch_d        = '0;
        status_armed_d = status_armed_q;
        io_rdata_d     = ITC_RDATA_IDLE;
        io_rvalid_d    = 1'b0;
        if (ctrl_hit) begin
            if (sel == ITC_SEL_READBACK) begin
                for (int i = 0; i < ITC_NUM_CNT; i++) begin
                    if (io_wdata[ITC_RB_CNT0 + i]) begin
                        // bits active low: 0 requests
                        if (!io_wdata[ITC_RB_NSTATUS]) begin
                            status_armed_d[i] = 1'b1;
                        end
                        if (!io_wdata[ITC_RB_NCOUNT]) begin
                            latch_d[i] = 1'b1;
                        end
                    end
                end
            end else if (io_wdata[ITC_ACC_HI:ITC_ACC_LO] == ITC_ACC_LATCH) begin
                latch_d[sel] = 1'b1;
            end else begin
                ctrl_we_d[sel] = 1'b1;
            end
        end
        if (io_wr && is_data_port(io_addr)) begin
            // core applies it at its mode's load point
            count_we_d[port_index(io_addr)] = 1'b1;
        end
        if (io_rd && is_data_port(io_addr)) begin
            io_rvalid_d = 1'b1;
            if (status_armed_q[port_index(io_addr)]) begin
                io_rdata_d = {out_sync_q[port_index(io_addr)],
                              pend[port_index(io_addr)],
                              acc[port_index(io_addr)],
                              mode[port_index(io_addr)],
                              bcd[port_index(io_addr)]};
                status_armed_d[port_index(io_addr)] = 1'b0;
            end
            // unarmed reads: count data comes from the core, idle value here
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            out_meta_q     <= '0;
            out_sync_q     <= '0;
            status_armed_q <= '0;
            io_rdata       <= ITC_RDATA_IDLE;
            io_rvalid      <= 1'b0;
            ctrl_we_q      <= '0;
            count_we_q     <= '0;
            latch_q        <= '0;
            wdata_q        <= '0;
        end else begin
            out_meta_q     <= cnt_out;
            out_sync_q     <= out_meta_q;
            status_armed_q <= status_armed_d;
            io_rdata       <= io_rdata_d;
            io_rvalid      <= io_rvalid_d;
            ctrl_we_q      <= ctrl_we_d;
            count_we_q     <= count_we_d;
            latch_q        <= latch_d;
            wdata_q        <= io_wdata;
        end
    end

    assign cnt_ctrl_we   = ctrl_we_q;
    assign cnt_count_we  = count_we_q;
    assign cnt_latch_req = latch_q;
    assign cnt_wdata     = wdata_q;
    assign cnt_mode0     = mode[0];
    assign cnt_mode1     = mode[1];
    assign cnt_mode2     = mode[2];
    assign cnt_bcd       = {bcd[2], bcd[1], bcd[0]};
    assign cnt_acc0      = acc[0];
    assign cnt_acc1      = acc[1];
    assign cnt_acc2      = acc[2];
endmodule : itc_control_status
`default_nettype wire

// ===== verification/itc_chk.sv
// Purpose: port checks for the timer control/status block
// Assumes: one request per cycle
// Notes:   counter 0 settings stand for all three
`timescale 1ns/1ns
`default_nettype none
module itc_chk
    import itc_pkg::*;
(
    // clock and reset
    input wire logic       mclk,
    input wire logic       sys_rst,
    // i/o port
    input wire logic       io_wr,
    input wire logic       io_rd,
    input wire logic [7:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic [7:0] io_rdata,
    input wire logic       io_rvalid,
    // counter side
    input wire logic [2:0] cnt_ctrl_we,
    input wire logic [2:0] cnt_mode0,
    input wire logic [2:0] cnt_bcd,
    input wire logic [1:0] cnt_acc0
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic cw;
    logic c0;
    assign cw = io_wr && io_addr == ITC_PORT_CTRL;
    assign c0 = cw && io_wdata[7:6] == 2'h0 && io_wdata[5:4] != 2'h0;
    a_read_valid: assert property (io_rvalid == $past(io_rd && io_addr >= ITC_PORT_CNT0
        && io_addr <= ITC_PORT_CNT2)) else $error("rvalid wrong");
    a_idle_rdata: assert property (!io_rvalid |-> io_rdata == ITC_RDATA_IDLE)
        else $error("rdata not idle");
    a_sel_zero: assert property (c0 |=> cnt_ctrl_we == 3'h1) else $error("sel");
    a_readback_only: assert property (cw && io_wdata[7:6] == 2'h3 |=> cnt_ctrl_we == 3'h0)
        else $error("readback programmed");
    a_acc_echo: assert property (c0 |=> cnt_acc0 == $past(io_wdata[5:4]))
        else $error("access code");
    a_mode_code: assert property (c0 |=> cnt_mode0 == ($past(io_wdata[2]) ?
        {1'b0, $past(io_wdata[2:1])} : $past(io_wdata[3:1]))) else $error("mode");
    a_bcd_bit: assert property (c0 |=> cnt_bcd[0] == $past(io_wdata[0]))
        else $error("bcd");
    a_latch_keep: assert property (cw && io_wdata[7:4] == 4'h0 |=> $stable(cnt_acc0)
        && $stable(cnt_mode0)) else $error("latch changed settings");
endmodule : itc_chk
bind itc_control_status itc_chk u_chk (.mclk, .sys_rst, .io_wr, .io_rd, .io_addr,
    .io_wdata, .io_rdata, .io_rvalid, .cnt_ctrl_we, .cnt_mode0, .cnt_bcd, .cnt_acc0);
`default_nettype wire

// ===== verification/tb.sv
// Purpose: self-checking bench for the timer control/status block
// Assumes: answers one cycle after each request
// Notes:   bench plays the counter cores
`timescale 1ns/1ns
`default_nettype none
module tb;
    import itc_pkg::*;
    logic       mclk = 1'b0;
    logic       sys_rst = 1'b1;
    logic       io_wr = 1'b0;
    logic       io_rd = 1'b0;
    logic [7:0] io_addr = 8'h00;
    logic [7:0] io_wdata = 8'h00;
    logic [7:0] io_rdata;
    logic       io_rvalid;
    logic [2:0] cnt_out = 3'h0;
    logic [2:0] cnt_loaded = 3'h0;
    logic [2:0] cnt_ctrl_we;
    logic [2:0] cnt_count_we;
    logic [2:0] cnt_latch_req;
    logic [7:0] cnt_wdata;
    int         n_mismatch = 0;
    int         tests_run = 0;
    always #4 mclk = ~mclk;
    itc_control_status dut (.mclk, .sys_rst, .io_wr, .io_rd, .io_addr, .io_wdata,
        .io_rdata, .io_rvalid, .cnt_out, .cnt_loaded, .cnt_ctrl_we, .cnt_count_we,
        .cnt_latch_req, .cnt_wdata, .cnt_mode0(), .cnt_mode1(), .cnt_mode2(),
        .cnt_bcd(), .cnt_acc0(), .cnt_acc1(), .cnt_acc2());
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        #1;
        io_wr = 1'b1;
        io_addr = a;
        io_wdata = d;
        @(posedge mclk);
        #1;
        io_wr = 1'b0;
    endtask : wr
    // reply lands at the taking edge and is checked 1 ns after it
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic v);
        @(posedge mclk);
        #1;
        io_rd = 1'b1;
        io_addr = a;
        @(posedge mclk);
        #1;
        io_rd = 1'b0;
        chk({7'h0, io_rvalid}, {7'h0, v});
        chk(io_rdata, exp);
    endtask : rd
    task automatic st(input int c, input logic [7:0] exp);
        wr(ITC_PORT_CTRL, 8'hE0 | (8'h02 << c));
        rd(ITC_PORT_CNT0 + 8'(c), exp, 1'b1);
    endtask : st
    task automatic t_reset;
        st(0, 8'h70);
        rd(ITC_PORT_CNT0, 8'h00, 1'b1);
        rd(ITC_PORT_CTRL, 8'h00, 1'b0);
        $display("reset test done");
    endtask : t_reset
    task automatic t_modes;
        logic [2:0] m;
        for (int i = 0; i < 8; i++) begin
            m = 3'(i);
            wr(ITC_PORT_CTRL, {4'h7, m, m[0]});
            st(1, {4'h7, m[1] ? {1'b0, m[1:0]} : m, m[0]});
        end
        $display("mode test done");
    endtask : t_modes
    task automatic t_access;
        cnt_out = 3'h4;
        repeat (3) @(posedge mclk);
        for (int a = 1; a < 4; a++) begin
            wr(ITC_PORT_CTRL, {2'h2, 2'(a), 4'hB});
            st(2, {2'h3, 2'(a), 4'hB});
        end
        wr(ITC_PORT_CTRL, 8'h80);
        st(2, 8'hFB);
        $display("access test done");
    endtask : t_access
    task automatic t_pending;
        wr(ITC_PORT_CTRL, 8'h30);
        chk({5'h0, cnt_ctrl_we}, 8'h01);
        cnt_loaded = 3'h1;
        @(posedge mclk);
        #1;
        cnt_loaded = 3'h0;
        st(0, 8'h30);
        rd(ITC_PORT_CNT1, 8'h00, 1'b1);
        wr(ITC_PORT_CNT0, 8'h12);
        chk({5'h0, cnt_count_we}, 8'h01);
        chk(cnt_wdata, 8'h12);
        st(0, 8'h70);
        // latch command on counter 0 must leave its settings alone
        wr(ITC_PORT_CTRL, 8'h00);
        chk({5'h0, cnt_latch_req}, 8'h01);
        st(0, 8'h70);
        // read-back asking for counts only: all three latch, no status armed
        wr(ITC_PORT_CTRL, 8'hDE);
        chk({5'h0, cnt_latch_req}, 8'h07);
        rd(ITC_PORT_CNT2, 8'h00, 1'b1);
        $display("pending test done");
    endtask : t_pending
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : print_verdict
    // whole run is about 120 cycles
    initial begin
        #100000;
        n_mismatch++;
        print_verdict;
    end
    initial begin
        repeat (10) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        t_reset;
        t_modes;
        t_access;
        t_pending;
        print_verdict;
    end
endmodule : tb
`default_nettype wire
